// *** inc/rpt_pkg.sv ***
package rpt_pkg;
   // register word indices; byte address is four times the index
   localparam logic [3:0] IDX_CTRL = 4'h0;
   localparam logic [3:0] IDX_MASK_TO = 4'h1;
   localparam logic [3:0] IDX_NR_TO_HI = 4'h2;
   localparam logic [3:0] IDX_NR_TO_LO = 4'h3;
   localparam logic [3:0] IDX_GPT_TO = 4'h4;
   localparam logic [3:0] IDX_WU_CTRL = 4'h5;
   localparam logic [3:0] IDX_CMD = 4'h6;
   localparam logic [3:0] IDX_STATUS = 4'h7;
   localparam logic [3:0] IDX_TIMER_IRQ = 4'h8;
   localparam logic [3:0] IDX_ERR_WU_IRQ = 4'h9;
   localparam int IDX_LSB = 2;
   localparam int IDX_MSB = 5;
   localparam int MAP_TOP = 6;

   // control register fields
   localparam int CB_NFC_ACTIVE = 0;
   localparam int CB_LP_TARGET = 1;
   localparam int CB_SQUELCH_EN = 2;
   localparam int CB_NR_STEP = 3;
   localparam int CB_NR_UNCOND = 4;
   localparam int CB_GPT_TRIG = 5;
   localparam int CB_WU_MODE = 7;
   localparam logic [7:0] CTRL_RST = 8'h00;

   typedef enum logic [1:0] {
      GT_NONE = 2'b00,
      GT_RX_START = 2'b01,
      GT_RX_END = 2'b10,
      GT_FIELD_OFF = 2'b11
   } rpt_gpt_trig_t;

   // command register bits, write one to act
   localparam int CMD_CLEAR = 0;
   localparam int CMD_MASK = 1;
   localparam int CMD_NR = 2;
   localparam int CMD_GPT = 3;
   localparam int CMD_WU = 4;

   // status and flag fields
   localparam int ST_RUN = 0;
   localparam int ST_WIN = 4;
   localparam int ST_SQUELCH = 5;
   localparam int ST_OBSERVE = 6;
   localparam int ST_FORCE_OFF = 7;
   localparam int TI_NR = 0;
   localparam int TI_GPT = 1;
   localparam int EI_WU = 0;

   // timer slots
   localparam int NT = 4;
   localparam int T_MASK = 0;
   localparam int T_NR = 1;
   localparam int T_GPT = 2;
   localparam int T_WU = 3;
   localparam int TW = 16;

   // steps in carrier periods; the input tick is one step of CARRIER_PER_TICK
   localparam int CARRIER_PER_TICK = 64;
   localparam int NR_LONG_STEP = 4096;
   localparam int LP_MASK_STEP = 512;
   localparam int NR_LONG_DIV = NR_LONG_STEP / CARRIER_PER_TICK;
   localparam int LP_MASK_DIV = LP_MASK_STEP / CARRIER_PER_TICK;
   localparam int PRE_W = $clog2(NR_LONG_DIV);

   // wake-up periods in ms, selected by a 3-bit field
   localparam logic [2:0] WU_SEL_RST = 3'h3;
   function automatic logic [15:0] rpt_wu_ms(input logic [2:0] sel);
      logic [15:0] ms;
      ms = 16'h0000;
      case (sel)
         3'h0: ms = 16'd10;
         3'h1: ms = 16'd20;
         3'h2: ms = 16'd50;
         3'h3: ms = 16'd100;
         3'h4: ms = 16'd200;
         3'h5: ms = 16'd400;
         3'h6: ms = 16'd600;
         default: ms = 16'd800;
      endcase
      return ms;
   endfunction
endpackage

// *** hdl/rpt_countdown.sv ***
`timescale 1ns/1ns
module rpt_countdown #(
   parameter int W = 16
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic start,
   input wire logic stop,
   input wire logic tick,
   input wire logic [W-1:0] load,
   output logic running,
   output logic expired
);
   typedef struct packed {
      logic run;
      logic [W-1:0] cnt;
   } rpt_cd_state_t;

   rpt_cd_state_t s_q;
   rpt_cd_state_t s_d;

   initial begin
      if (W < 2) $error("rpt_countdown width too small");
   end

   // expiry is seen even if a stop or restart lands in the same cycle
   assign expired = s_q.run & tick & (s_q.cnt == W'(1));
   assign running = s_q.run;

   always_comb begin
      s_d = s_q;
      if (start) begin
         // a zero setting leaves the timer idle
         s_d.run = (load != '0);
         s_d.cnt = load;
      end else if (stop) begin
         s_d.run = 1'b0;
      end else if (s_q.run && tick) begin
         s_d.cnt = s_q.cnt - W'(1);
         if (s_q.cnt == W'(1)) begin
            s_d.run = 1'b0;
         end
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
      end else begin
         s_q <= s_d;
      end
   end
endmodule

// *** hdl/rpt_timers.sv ***
// The register addresses and the AHB-Lite register port were left to the implementer.
`timescale 1ns/1ns
// Behaviour
// - clear stops all timers but wake-up; unconditional mode keeps no-response running.
// - end of transmit starts no-response timer, and mask receive timer outside active peer and low power target modes.
// - receive window held closed while mask receive timer runs.
// - squelch on while mask timer runs if enabled; mask expiry raises no flag.
// - in active peer mode, mask timer starts on peer field on.
// - low power target: command starts mask timer, step 512 carrier periods, then observe.
// - no-response timeout from two registers; expiry sets its flag.
// - no-response step selects 64 or 4096 carrier periods.
// - conditional mode: expiry flags and closes window; reply start stops silently except in active peer mode.
// - unconditional mode: expiry always flags; closes window only if no reply busy.
// - no-response command starts or restarts; ignored in active peer mode.
// - active mode: no-response expiry before peer field on raises flag.
// - general timer triggered by rx start, rx end or, in active peer mode only, field off; expiry flags.
// - general timer command starts or restarts it from its setting.
// - wake-up command refused in wake-up mode; runs rc oscillator; sets wake-up flag.
// - carrier timers need the crystal; wake-up timer runs from the rc clock.
// - wake-up period selects 10 to 800 ms, 100 ms after reset.
module rpt_timers #(
   parameter int RC_KHZ = 32
) (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic carrier_div64_tick,
   input wire logic xtal_running,
   input wire logic rc_osc_clk,
   input wire logic tx_done,
   input wire logic rx_reply_start,
   input wire logic rx_reply_end,
   input wire logic rx_reply_busy,
   input wire logic peer_field_on,
   input wire logic peer_field_off,
   output logic receive_window_active,
   output logic squelch_on,
   output logic rx_observe,
   output logic rc_osc_enable,
   output logic irq
);
   import rpt_pkg::*;

   default clocking cb @(posedge hclk); endclocking
   default disable iff (!hresetn);

   typedef struct packed {
      logic wr_pend;
      logic wr_ok;
      logic [3:0] wr_idx;
      logic [31:0] rdata;
      logic [7:0] ctrl;
      logic [7:0] mask_to;
      logic [15:0] nr_to;
      logic [15:0] gpt_to;
      logic [2:0] wu_sel;
      logic [PRE_W-1:0] pre;
      logic force_off;
      logic observe;
      logic win;
      logic squelch;
      logic nr_flag;
      logic gpt_flag;
      logic wu_flag;
      logic irq;
      logic rc_s1;
      logic rc_s2;
      logic rc_s3;
   } rpt_state_t;

   rpt_state_t s_q;
   rpt_state_t s_d;

   logic [NT-1:0] t_start;
   logic [NT-1:0] t_stop;
   logic [NT-1:0] t_tick;
   logic [NT-1:0] t_run;
   logic [NT-1:0] t_exp;
   logic [TW-1:0] t_load [NT];
   logic acc;
   logic [7:0] cmd;
   logic clr;
   logic nfc_act;
   logic lp_tgt;
   logic uncond;
   logic ctick;
   logic rc_tick;
   logic [31:0] wu_cnt;

   initial begin
      if (RC_KHZ < 1 || RC_KHZ > 80) $error("rc clock rate out of range for the wake-up counter");
   end

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = s_q.rdata;
   assign receive_window_active = s_q.win;
   assign squelch_on = s_q.squelch;
   assign rx_observe = s_q.observe;
   assign rc_osc_enable = t_run[T_WU];
   assign irq = s_q.irq;

   assign nfc_act = s_q.ctrl[CB_NFC_ACTIVE];
   assign lp_tgt = s_q.ctrl[CB_LP_TARGET];
   assign uncond = s_q.ctrl[CB_NR_UNCOND];
   // crystal-derived timers freeze while the crystal is stopped
   assign ctick = carrier_div64_tick & xtal_running;
   assign rc_tick = s_q.rc_s2 & ~s_q.rc_s3;
   assign wu_cnt = 32'(rpt_wu_ms(s_q.wu_sel)) * 32'(RC_KHZ);

   genvar gi;
   generate
      for (gi = 0; gi < NT; gi++) begin : g_tmr
         rpt_countdown #(.W(TW)) u_cd (
            .hclk(hclk),
            .hresetn(hresetn),
            .start(t_start[gi]),
            .stop(t_stop[gi]),
            .tick(t_tick[gi]),
            .load(t_load[gi]),
            .running(t_run[gi]),
            .expired(t_exp[gi])
         );
      end
   endgenerate

   always_comb begin
      s_d = s_q;
      cmd = 8'h00;
      t_start = '0;
      t_stop = '0;
      t_tick = '0;
      acc = hsel & hready & htrans[1];

      // rc clock pin: two flops, then an edge detector on the second
      s_d.rc_s1 = rc_osc_clk;
      s_d.rc_s2 = s_q.rc_s1;
      s_d.rc_s3 = s_q.rc_s2;

      // data phase of a write
      if (s_q.wr_pend && s_q.wr_ok) begin
         case (s_q.wr_idx)
            IDX_CTRL: s_d.ctrl = hwdata[7:0];
            IDX_MASK_TO: s_d.mask_to = hwdata[7:0];
            IDX_NR_TO_HI: s_d.nr_to[15:8] = hwdata[7:0];
            IDX_NR_TO_LO: s_d.nr_to[7:0] = hwdata[7:0];
            IDX_GPT_TO: s_d.gpt_to = hwdata[15:0];
            IDX_WU_CTRL: s_d.wu_sel = hwdata[2:0];
            IDX_CMD: cmd = hwdata[7:0];
            default: cmd = 8'h00;
         endcase
      end
      s_d.wr_pend = acc & hwrite;
      s_d.wr_ok = (haddr[31:MAP_TOP] == '0);
      s_d.wr_idx = haddr[IDX_MSB:IDX_LSB];
      // clear outranks any mask, no-response or general timer start written in the same word; a wake-up start still goes ahead
      clr = cmd[CMD_CLEAR];

      // shared prescaler over carrier ticks
      if (ctick) begin
         s_d.pre = s_q.pre + PRE_W'(1);
      end
      t_tick[T_MASK] = lp_tgt ? (ctick && s_q.pre[2:0] == 3'(LP_MASK_DIV - 1)) : ctick;
      t_tick[T_NR] = s_q.ctrl[CB_NR_STEP] ? (ctick && s_q.pre == PRE_W'(NR_LONG_DIV - 1)) : ctick;
      t_tick[T_GPT] = ctick;
      t_tick[T_WU] = rc_tick;

      t_load[T_MASK] = TW'(s_q.mask_to);
      t_load[T_NR] = s_q.nr_to;
      t_load[T_GPT] = s_q.gpt_to;
      t_load[T_WU] = wu_cnt[TW-1:0];

      // mask receive timer
      if (!clr) begin
         if (lp_tgt) begin
            t_start[T_MASK] = cmd[CMD_MASK];
         end else if (nfc_act) begin
            t_start[T_MASK] = peer_field_on | cmd[CMD_MASK];
         end else begin
            t_start[T_MASK] = tx_done | cmd[CMD_MASK];
         end
      end
      t_stop[T_MASK] = clr;

      // no-response timer
      if (!clr) begin
         t_start[T_NR] = tx_done | (cmd[CMD_NR] & ~nfc_act);
      end
      t_stop[T_NR] = (clr & ~uncond)
                   | (rx_reply_start & ~uncond & ~nfc_act)
                   | (peer_field_on & nfc_act);

      // general purpose timer
      if (!clr) begin
         t_start[T_GPT] = cmd[CMD_GPT];
         unique case (rpt_gpt_trig_t'(s_q.ctrl[CB_GPT_TRIG +: 2]))
            GT_NONE: ;
            GT_RX_START: t_start[T_GPT] = t_start[T_GPT] | rx_reply_start;
            GT_RX_END: t_start[T_GPT] = t_start[T_GPT] | rx_reply_end;
            GT_FIELD_OFF: t_start[T_GPT] = t_start[T_GPT] | (peer_field_off & nfc_act);
         endcase
      end
      t_stop[T_GPT] = clr;

      // wake-up timer ignores clear and is refused in wake-up mode
      t_start[T_WU] = cmd[CMD_WU] & ~s_q.ctrl[CB_WU_MODE];

      // receive window
      if (t_start[T_NR] || t_start[T_MASK]) begin
         s_d.force_off = 1'b0;
      end
      if (t_exp[T_NR] && !(uncond && rx_reply_busy)) begin
         s_d.force_off = 1'b1;
      end
      if (t_start[T_MASK] || clr || rx_reply_start) begin
         s_d.observe = 1'b0;
      end
      if (t_exp[T_MASK] && lp_tgt) begin
         s_d.observe = 1'b1;
      end
      // window and squelch lag the timer's run bit by one cycle
      s_d.win = ~t_run[T_MASK] & ~s_d.force_off;
      s_d.squelch = t_run[T_MASK] & s_q.ctrl[CB_SQUELCH_EN];

      // read: data comes from the post-write copy so a write is visible at once
      s_d.rdata = 32'h0000_0000;
      if (acc && !hwrite && haddr[31:MAP_TOP] == '0) begin
         case (haddr[IDX_MSB:IDX_LSB])
            IDX_CTRL: s_d.rdata[7:0] = s_d.ctrl;
            IDX_MASK_TO: s_d.rdata[7:0] = s_d.mask_to;
            IDX_NR_TO_HI: s_d.rdata[7:0] = s_d.nr_to[15:8];
            IDX_NR_TO_LO: s_d.rdata[7:0] = s_d.nr_to[7:0];
            IDX_GPT_TO: s_d.rdata[15:0] = s_d.gpt_to;
            IDX_WU_CTRL: s_d.rdata[2:0] = s_d.wu_sel;
            IDX_STATUS: begin
               s_d.rdata[ST_RUN +: NT] = t_run;
               s_d.rdata[ST_WIN] = s_q.win;
               s_d.rdata[ST_SQUELCH] = s_q.squelch;
               s_d.rdata[ST_OBSERVE] = s_q.observe;
               s_d.rdata[ST_FORCE_OFF] = s_q.force_off;
            end
            IDX_TIMER_IRQ: begin
               s_d.rdata[TI_NR] = s_q.nr_flag;
               s_d.rdata[TI_GPT] = s_q.gpt_flag;
               s_d.nr_flag = 1'b0;
               s_d.gpt_flag = 1'b0;
            end
            IDX_ERR_WU_IRQ: begin
               s_d.rdata[EI_WU] = s_q.wu_flag;
               s_d.wu_flag = 1'b0;
            end
            default: s_d.rdata = 32'h0000_0000;
         endcase
      end
      // a new expiry beats the read clear; mask timer expiry sets nothing
      if (t_exp[T_NR]) begin
         s_d.nr_flag = 1'b1;
      end
      if (t_exp[T_GPT]) begin
         s_d.gpt_flag = 1'b1;
      end
      if (t_exp[T_WU]) begin
         s_d.wu_flag = 1'b1;
      end
      s_d.irq = s_d.nr_flag | s_d.gpt_flag | s_d.wu_flag;
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s_q <= '0;
         s_q.ctrl <= CTRL_RST;
         s_q.wu_sel <= WU_SEL_RST;
         s_q.win <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   sequence s_flag_read;
      acc && !hwrite && haddr[31:MAP_TOP] == '0 && haddr[IDX_MSB:IDX_LSB] == IDX_TIMER_IRQ;
   endsequence
   sequence s_tx_plain;
      tx_done && !nfc_act && !lp_tgt && !clr;
   endsequence

   property p_clear_stops;
      clr |=> !t_run[T_MASK] && !t_run[T_GPT];
   endproperty
   a_clear_stops: assert property (p_clear_stops) else $error("clear left a timer running");

   property p_clear_keeps_wu;
      clr && t_run[T_WU] && !t_exp[T_WU] |=> t_run[T_WU];
   endproperty
   a_clear_keeps_wu: assert property (p_clear_keeps_wu) else $error("clear stopped wake-up timer");

   property p_tx_start;
      s_tx_plain and (s_q.mask_to != 8'h00 && s_q.nr_to != 16'h0000) |=> t_run[T_MASK] && t_run[T_NR];
   endproperty
   a_tx_start: assert property (p_tx_start) else $error("end of transmit did not start timers");

   property p_mask_closes;
      t_run[T_MASK] |=> !receive_window_active ##1 (!receive_window_active || !$past(t_run[T_MASK]));
   endproperty
   a_mask_closes: assert property (p_mask_closes) else $error("window open during mask time");

   property p_squelch;
      t_run[T_MASK] && s_q.ctrl[CB_SQUELCH_EN] |=> squelch_on;
   endproperty
   a_squelch: assert property (p_squelch) else $error("squelch off during mask time");

   property p_nr_flag;
      t_exp[T_NR] |=> s_q.nr_flag && irq;
   endproperty
   a_nr_flag: assert property (p_nr_flag) else $error("no-response expiry lost");

   property p_nr_window;
      t_exp[T_NR] && !(uncond && rx_reply_busy) && !t_start[T_NR] && !t_start[T_MASK] |=> !receive_window_active;
   endproperty
   a_nr_window: assert property (p_nr_window) else $error("window not forced closed");

   property p_reply_stops;
      rx_reply_start && !uncond && !nfc_act && !t_start[T_NR] |=> !t_run[T_NR];
   endproperty
   a_reply_stops: assert property (p_reply_stops) else $error("reply start did not stop timer");

   property p_nr_cmd_active;
      nfc_act && !t_run[T_NR] && !tx_done |=> !t_run[T_NR];
   endproperty
   a_nr_cmd_active: assert property (p_nr_cmd_active) else $error("no-response started by command in active mode");

   property p_wu_refused;
      cmd[CMD_WU] && s_q.ctrl[CB_WU_MODE] && !t_run[T_WU] |=> !t_run[T_WU] [*2];
   endproperty
   a_wu_refused: assert property (p_wu_refused) else $error("wake-up start accepted in wake-up mode");

   property p_read_clears;
      s_flag_read ##0 (!t_exp[T_NR] && !t_exp[T_GPT]) |=> !s_q.nr_flag && !s_q.gpt_flag;
   endproperty
   a_read_clears: assert property (p_read_clears) else $error("flag survived its read");

   property p_no_xtal;
      !xtal_running && t_run[T_GPT] && !t_start[T_GPT] && !t_stop[T_GPT] |=> t_run[T_GPT];
   endproperty
   a_no_xtal: assert property (p_no_xtal) else $error("timer advanced without crystal");
endmodule

// *** verif/rpt_host_model.sv ***
`timescale 1ns/1ns
module rpt_host_model (
   input wire logic hclk,
   input wire logic hreadyout,
   input wire logic [31:0] hrdata,
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0000_0000;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0000_0000;
   end
   // one word transfer; the caller enters just after a rising edge
   task automatic xfer(input logic w, input logic [3:0] idx, input logic [31:0] wd, output logic [31:0] rd);
      hsel <= 1'b1;
      haddr <= {26'h0, idx, 2'h0};
      htrans <= 2'h2;
      hwrite <= w;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      // on a read the data lines toggle so no stale word looks valid
      hwdata <= w ? wd : ~hwdata;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
         @(posedge hclk);
      rd = hrdata;
   endtask
endmodule

// *** verif/rpt_testbench.sv ***
`timescale 1ns/1ns
module testbench;
   import rpt_pkg::*;
   localparam int E_TX = 0;
   localparam int E_RXS = 1;
   localparam int E_RXE = 2;
   localparam int E_ON = 3;
   localparam int E_OFF = 4;
   logic hclk, hresetn, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, rdv;
   logic [1:0] htrans, rc_cnt;
   logic [2:0] hsize, obs;
   logic tick, xtal_running, rc_osc_clk, rx_reply_busy;
   logic receive_window_active, squelch_on, rx_observe, rc_osc_enable, irq;
   logic [4:0] evs;
   int failures;
   int checked;
   assign obs = {rx_observe, receive_window_active, irq};

   rpt_host_model host (.hclk(hclk), .hreadyout(hreadyout), .hrdata(hrdata), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
   // one rc tick per ms keeps the wake-up count short
   rpt_timers #(.RC_KHZ(1)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
      .hrdata(hrdata), .carrier_div64_tick(tick), .xtal_running(xtal_running), .rc_osc_clk(rc_osc_clk),
      .tx_done(evs[E_TX]), .rx_reply_start(evs[E_RXS]), .rx_reply_end(evs[E_RXE]), .rx_reply_busy(rx_reply_busy),
      .peer_field_on(evs[E_ON]), .peer_field_off(evs[E_OFF]), .receive_window_active(receive_window_active),
      .squelch_on(squelch_on), .rx_observe(rx_observe), .rc_osc_enable(rc_osc_enable), .irq(irq));

   initial begin
      hclk = 1'b0;
      forever #5 hclk = ~hclk;
   end
   // the rc oscillator stands still unless the design enables it
   always @(posedge hclk) begin
      if (rc_osc_enable !== 1'b1) begin
         rc_cnt <= 2'h0;
         rc_osc_clk <= 1'b0;
      end else if (rc_cnt == 2'h2) begin
         rc_cnt <= 2'h0;
         rc_osc_clk <= ~rc_osc_clk;
      end else begin
         rc_cnt <= rc_cnt + 2'h1;
      end
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge hclk);
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      checked++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] idx, input logic [31:0] d);
      host.xfer(1'b1, idx, d, rdv);
   endtask
   task automatic rdc(input logic [3:0] idx, input logic [31:0] m, input logic [31:0] exp, input string what);
      host.xfer(1'b0, idx, 32'h0, rdv);
      chk(rdv & m, exp, what);
   endtask
   // callers let an edge pass before the next pulse
   task automatic ev(input int i);
      evs[i] <= 1'b1;
      cyc(1);
      evs <= 5'h00;
   endtask
   task automatic wait_hi(input int sel, input int n);
      int k;
      k = 0;
      while (k < n && obs[sel] !== 1'b1) begin
         @(posedge hclk);
         k++;
      end
   endtask

   task automatic t_reset;
      chk({29'h0, squelch_on, receive_window_active, irq}, 32'h2, "idle outputs");
      rdc(IDX_WU_CTRL, 32'hffff_ffff, 32'h3, "wake-up period reset");
      rdc(IDX_CTRL, 32'hffff_ffff, 32'h0, "control reset");
      wr(IDX_MASK_TO, 32'h0000_01ab);
      rdc(IDX_MASK_TO, 32'hffff_ffff, 32'hab, "mask timeout width");
      wr(4'ha, 32'hffff_ffff);
      rdc(4'ha, 32'hffff_ffff, 32'h0, "unmapped word");
      rdc(IDX_CMD, 32'hffff_ffff, 32'h0, "command reads zero");
      chk({30'h0, hresp, hreadyout}, 32'h1, "okay response, no wait");
   endtask
   task automatic t_mask;
      wr(IDX_CTRL, 32'h4);
      wr(IDX_MASK_TO, 32'h8);
      ev(E_TX);
      cyc(2);
      chk({30'h0, receive_window_active, squelch_on}, 32'h1, "window shut, squelch");
      rdc(IDX_STATUS, 32'hff, 32'h21, "mask alone running");
      wait_hi(1, 20);
      cyc(2);
      chk({29'h0, squelch_on, receive_window_active, irq}, 32'h2, "mask expiry quiet");
   endtask
   task automatic t_nr;
      wr(IDX_CTRL, 32'h0);
      wr(IDX_MASK_TO, 32'h0);
      wr(IDX_NR_TO_HI, 32'h1);
      wr(IDX_NR_TO_LO, 32'h2);
      ev(E_TX);
      cyc(200);
      chk({31'h0, irq}, 32'h0, "no-response early");
      wait_hi(0, 100);
      chk({30'h0, receive_window_active, irq}, 32'h1, "no-response expiry");
      rdc(IDX_TIMER_IRQ, 32'hff, 32'h1, "no-response flag");
      rdc(IDX_TIMER_IRQ, 32'hff, 32'h0, "flag cleared by read");
      wr(IDX_NR_TO_HI, 32'h0);
      wr(IDX_NR_TO_LO, 32'h14);
      ev(E_TX);
      cyc(3);
      ev(E_RXS);
      cyc(40);
      rdc(IDX_TIMER_IRQ, 32'hff, 32'h0, "reply stops timer");
      chk({30'h0, receive_window_active, irq}, 32'h2, "window stays open");
   endtask
   task automatic t_uncond;
      wr(IDX_CTRL, 32'h10);
      wr(IDX_MASK_TO, 32'h1e);
      wr(IDX_NR_TO_LO, 32'h10);
      rx_reply_busy <= 1'b1;
      ev(E_RXS);
      wr(IDX_CMD, 32'h6);
      wr(IDX_CMD, 32'h1);
      rdc(IDX_STATUS, 32'hf, 32'h2, "clear spares no-response");
      wait_hi(0, 30);
      chk({30'h0, receive_window_active, irq}, 32'h3, "expiry during reply");
      rdc(IDX_TIMER_IRQ, 32'hff, 32'h1, "unconditional flag");
      rx_reply_busy <= 1'b0;
      wr(IDX_CMD, 32'h4);
      wait_hi(0, 30);
      chk({30'h0, receive_window_active, irq}, 32'h1, "expiry without reply");
      rdc(IDX_TIMER_IRQ, 32'hff, 32'h1, "second flag");
   endtask
   task automatic t_active;
      wr(IDX_CTRL, 32'h8);
      wr(IDX_NR_TO_LO, 32'h2);
      wr(IDX_CMD, 32'h4);
      cyc(60);
      chk({31'h0, irq}, 32'h0, "long step early");
      wait_hi(0, 80);
      rdc(IDX_TIMER_IRQ, 32'hff, 32'h1, "long step expiry");
      wr(IDX_CTRL, 32'h1);
      wr(IDX_MASK_TO, 32'h6);
      wr(IDX_NR_TO_LO, 32'h8);
      wr(IDX_CMD, 32'h4);
      rdc(IDX_STATUS, 32'hf, 32'h0, "command ignored");
      ev(E_TX);
      cyc(3);
      chk({31'h0, receive_window_active}, 32'h1, "mask waits for peer");
      wait_hi(0, 20);
      rdc(IDX_TIMER_IRQ, 32'hff, 32'h1, "peer field late");
      ev(E_ON);
      cyc(2);
      chk({31'h0, receive_window_active}, 32'h0, "peer field starts mask");
      wait_hi(1, 20);
      chk({31'h0, receive_window_active}, 32'h1, "mask over");
   endtask
   task automatic t_gpt;
      wr(IDX_GPT_TO, 32'h4);
      for (int t = 1; t < 4; t++) begin
         wr(IDX_CTRL, 32'(t << 5) | 32'(t == 3));
         ev(t == 3 ? E_OFF : t);
         wait_hi(0, 20);
         rdc(IDX_TIMER_IRQ, 32'hff, 32'h2, "general timer trigger");
      end
      wr(IDX_CTRL, 32'h0);
      wr(IDX_GPT_TO, 32'h1e);
      wr(IDX_CMD, 32'h8);
      cyc(20);
      wr(IDX_CMD, 32'h8);
      cyc(20);
      chk({31'h0, irq}, 32'h0, "restart from full count");
      wait_hi(0, 20);
      rdc(IDX_TIMER_IRQ, 32'hff, 32'h2, "restarted expiry");
   endtask
   task automatic t_wake;
      wr(IDX_CTRL, 32'h80);
      wr(IDX_CMD, 32'h10);
      cyc(3);
      chk({31'h0, rc_osc_enable}, 32'h0, "refused in wake-up mode");
      wr(IDX_CTRL, 32'h0);
      wr(IDX_WU_CTRL, 32'h0);
      wr(IDX_GPT_TO, 32'h4);
      xtal_running <= 1'b0;
      wr(IDX_CMD, 32'h10);
      wr(IDX_CMD, 32'h1);
      wr(IDX_CMD, 32'h8);
      cyc(2);
      chk({31'h0, rc_osc_enable}, 32'h1, "rc oscillator on through clear");
      cyc(30);
      chk({31'h0, irq}, 32'h0, "shortest period early");
      wait_hi(0, 150);
      rdc(IDX_ERR_WU_IRQ, 32'hff, 32'h1, "wake-up flag");
      rdc(IDX_TIMER_IRQ, 32'hff, 32'h0, "frozen without crystal");
      xtal_running <= 1'b1;
      wait_hi(0, 20);
      rdc(IDX_TIMER_IRQ, 32'hff, 32'h2, "resumes with crystal");
   endtask
   task automatic t_lp;
      wr(IDX_CTRL, 32'h2);
      wr(IDX_NR_TO_LO, 32'h0);
      wr(IDX_MASK_TO, 32'h2);
      ev(E_TX);
      cyc(3);
      chk({31'h0, receive_window_active}, 32'h1, "transmit end leaves mask");
      wr(IDX_CMD, 32'h2);
      cyc(5);
      chk({31'h0, rx_observe}, 32'h0, "eight-fold step");
      wait_hi(2, 20);
      chk({31'h0, rx_observe}, 32'h1, "observe after expiry");
      ev(E_RXS);
      cyc(2);
      chk({30'h0, rx_observe, irq}, 32'h0, "reply ends observe");
   endtask

   task automatic end_of_test;
      $display("checks %0d failures %0d", checked, failures);
      if (failures == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      hresetn = 1'b0;
      tick = 1'b1;
      xtal_running = 1'b1;
      rc_osc_clk = 1'b0;
      rc_cnt = 2'h0;
      evs = 5'h00;
      rx_reply_busy = 1'b0;
      failures = 0;
      checked = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      t_reset();
      t_mask();
      t_nr();
      t_uncond();
      t_active();
      t_gpt();
      t_wake();
      t_lp();
      end_of_test();
   end
   initial begin
      repeat (10000) @(posedge hclk);
      failures++;
      $display("[FAIL] %0t watchdog expired", $time);
      end_of_test();
   end
endmodule
